// file: xip_pkg.sv
// package: constants and carrier types for the xip mode control block
package xip_pkg;
  localparam int VCR_XIP_BIT = 3;
  localparam logic VCR_XIP_RESET = 1'b1;
  localparam int NVCR_XIP_LO = 9;
  localparam int NVCR_XIP_HI = 11;
  localparam logic [2:0] NVCR_XIP_OFF = 3'h7;
  localparam logic [7:0] CMD_FAST_READ = 8'h0B;
  localparam logic [7:0] CMD_DUAL_IO_READ = 8'hBB;
  localparam logic [7:0] CMD_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
  localparam logic [7:0] CMD_RESET_MEMORY = 8'h99;
  localparam int ADDR_BITS = 24;
  localparam logic [4:0] ADDR_CLKS_EXT = 5'h18;
  localparam logic [4:0] ADDR_CLKS_DUAL = 5'h0C;
  localparam logic [4:0] ADDR_CLKS_QUAD = 5'h06;
  localparam logic [4:0] CMD_CLKS_EXT = 5'h08;
  localparam logic [4:0] CMD_CLKS_DUAL = 5'h04;
  localparam logic [4:0] CMD_CLKS_QUAD = 5'h02;

  typedef enum logic [1:0] {
    PROTO_EXT = 2'h0,
    PROTO_DUAL = 2'h1,
    PROTO_QUAD = 2'h2
  } proto_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_ADDR = 3'h3,
    ST_CONFIRM = 3'h2,
    ST_DATA = 3'h6,
    ST_IGNORE = 3'h7
  } state_type;

  typedef struct packed {
    logic select_n;
    logic sclk;
    logic [3:0] dq;
  } link_type;

  typedef struct packed {
    logic xip_active;
    logic vcr_xip_n;
    logic reset_enabled;
    logic soft_reset;
  } status_type;
endpackage

// file: sync2.sv
// two flip-flop synchroniser for link pins
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [WIDTH-1:0] D,
  output logic [WIDTH-1:0] Q
);
  logic [WIDTH-1:0] meta_q;
  // first stage read only by the second
  always_ff @(posedge CLK) begin
    if (RST) begin
      meta_q <= '1;
      Q <= '1;
    end else begin
      meta_q <= D;
      Q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: xip_mode_control.sv
// xip mode control: entry, address-only access and exit of execute-in-place
`timescale 1ns/100ps
`default_nettype none
// Operation
// R1: volatile enable bit 3 at 0 arms xip entry; at 1 volatile entry blocked.
// R2: armed device enters xip when confirm bit of next fast read is 0.
// R3: in xip each select starts with address bits at current protocol width.
// R4: confirm bit 1 ending xip sets volatile bit 3 back to 1.
// R5: basic variant enters xip on confirm 0 after any fast read.
// R6: nonvolatile bits 11..9 selecting xip give xip active at power up.
// R7: confirm bit is line 0 level at first dummy clock of fast read.
// R8: host gives at least one dummy clock in xip reads.
// R9: confirm 0 keeps xip, confirm 1 returns to command mode.
// R10: dual ignores line 1, quad ignores lines 3..1 at first dummy clock.
// R11: reset pin low pulse exits xip, restoring nonvolatile power-up state.
// R12: reset pin acts only while deselected.
// R13: quad forced exit: line 0 high for seven clocks, then deselect.
// R14: dual forced exit: line 0 high for 13 clocks, then deselect.
// R15: extended forced exit: line 0 high for 25 clocks, then deselect.
// R16: forced exit acts as confirm 1; no reset, no program abort.
// R17: after forced exit host sends reset enable then reset memory.
// R18: soft reset is 66 hex then 99 hex in separate selects.
// R19: xip flag cleared at reset unless nonvolatile boot, updated at confirm samples.
module xip_mode_control (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SELECT_N,
  input wire logic SCLK,
  input wire logic [3:0] DQ_IN,
  input wire logic RESET_PIN_N,
  input wire logic RESET_PIN_ENABLE,
  input wire logic BASIC_XIP,
  input wire logic [1:0] PROTOCOL,
  input wire logic [11:0] NVCR,
  input wire logic VCR_WRITE,
  input wire logic VCR_XIP_WDATA,
  input wire logic [4:0] DUMMY_CLKS,
  output logic XIP_ACTIVE,
  output logic VCR_XIP_N,
  output logic ADDR_VALID,
  output logic [23:0] ADDR,
  output logic SOFT_RESET,
  output logic RESET_ENABLED
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  xip_pkg::link_type link_raw, link_s;
  logic rst_pin_s;
  assign link_raw = '{select_n: SELECT_N, sclk: SCLK, dq: DQ_IN};
  sync2 #(.WIDTH(7)) u_sync (
    .CLK(CLK),
    .RST(RST),
    .D({link_raw, RESET_PIN_N}),
    .Q({link_s, rst_pin_s})
  );

  logic sclk_q, sel_q, rst_pin_q;
  always_ff @(posedge CLK) begin
    if (RST) begin
      // same level as the synchroniser's reset, so no false edge follows release
      sclk_q <= 1'b1;
      sel_q <= 1'b1;
      rst_pin_q <= 1'b1;
    end else begin
      sclk_q <= link_s.sclk;
      sel_q <= link_s.select_n;
      rst_pin_q <= rst_pin_s;
    end
  end
  logic rise, sel_start, sel_end, pin_pulse_end;
  assign rise = link_s.sclk & ~sclk_q & ~link_s.select_n;
  assign sel_start = sel_q & ~link_s.select_n;
  assign sel_end = ~sel_q & link_s.select_n;
  // reset pulse counted on its rising edge, only while deselected
  assign pin_pulse_end = RESET_PIN_ENABLE & rst_pin_s & ~rst_pin_q & link_s.select_n; // [R11] [R12]

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [4:0] addr_clks(input logic [1:0] p);
    case (p)
      xip_pkg::PROTO_DUAL: addr_clks = xip_pkg::ADDR_CLKS_DUAL;
      xip_pkg::PROTO_QUAD: addr_clks = xip_pkg::ADDR_CLKS_QUAD;
      default: addr_clks = xip_pkg::ADDR_CLKS_EXT;
    endcase
  endfunction
  function automatic logic [4:0] cmd_clks(input logic [1:0] p);
    case (p)
      xip_pkg::PROTO_DUAL: cmd_clks = xip_pkg::CMD_CLKS_DUAL;
      xip_pkg::PROTO_QUAD: cmd_clks = xip_pkg::CMD_CLKS_QUAD;
      default: cmd_clks = xip_pkg::CMD_CLKS_EXT;
    endcase
  endfunction
  function automatic logic is_fast_read(input logic [7:0] c);
    is_fast_read = (c == xip_pkg::CMD_FAST_READ) || (c == xip_pkg::CMD_DUAL_IO_READ) ||
                   (c == xip_pkg::CMD_QUAD_IO_READ);
  endfunction

  logic nv_boot;
  assign nv_boot = NVCR[xip_pkg::NVCR_XIP_HI:xip_pkg::NVCR_XIP_LO] != xip_pkg::NVCR_XIP_OFF;

  // ****************************************************************
  // frame sequencer
  // ****************************************************************
  xip_pkg::state_type state_q;
  logic [4:0] cnt_q;
  logic [7:0] cmd_q;
  logic [23:0] addr_q;
  logic [7:0] cmd_next;
  logic [23:0] addr_next;
  logic xip_q, vcr_q, rst_en_q, confirm;

  always_comb begin
    cmd_next = cmd_q;
    addr_next = addr_q;
    case (PROTOCOL)
      xip_pkg::PROTO_DUAL: begin
        cmd_next = {cmd_q[5:0], link_s.dq[1:0]};
        addr_next = {addr_q[21:0], link_s.dq[1:0]};
      end
      xip_pkg::PROTO_QUAD: begin
        cmd_next = {cmd_q[3:0], link_s.dq};
        addr_next = {addr_q[19:0], link_s.dq};
      end
      default: begin
        cmd_next = {cmd_q[6:0], link_s.dq[0]};
        addr_next = {addr_q[22:0], link_s.dq[0]};
      end
    endcase
  end

  // only line 0 is looked at; upper lines are don't care here
  assign confirm = link_s.dq[0]; // [R7] [R10]

  always_ff @(posedge CLK) begin
    if (RST || sel_end) begin
      state_q <= xip_pkg::ST_IDLE;
      cnt_q <= 5'h00;
    end else if (sel_start) begin
      // in xip the frame opens straight into the address phase
      state_q <= xip_q ? xip_pkg::ST_ADDR : xip_pkg::ST_CMD; // [R3]
      cnt_q <= 5'h00;
    end else if (rise) begin
      case (state_q)
        xip_pkg::ST_CMD: begin
          cmd_q <= cmd_next;
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == cmd_clks(PROTOCOL) - 5'h01) begin
            cnt_q <= 5'h00;
            state_q <= is_fast_read(cmd_next) ? xip_pkg::ST_ADDR : xip_pkg::ST_IGNORE;
          end
        end
        xip_pkg::ST_ADDR: begin
          addr_q <= addr_next; // [R3]
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == addr_clks(PROTOCOL) - 5'h01) begin
            cnt_q <= 5'h00;
            state_q <= xip_pkg::ST_CONFIRM;
          end
        end
        xip_pkg::ST_CONFIRM: state_q <= xip_pkg::ST_DATA; // [R8]
        xip_pkg::ST_DATA: state_q <= xip_pkg::ST_DATA;
        xip_pkg::ST_IGNORE: state_q <= xip_pkg::ST_IGNORE;
        default: state_q <= xip_pkg::ST_IDLE;
      endcase
    end
  end

  logic sample;
  assign sample = rise && state_q == xip_pkg::ST_CONFIRM;
  // forced exit: frame ends before the confirm clock with line 0 high
  logic forced_exit, line0_hi_q;
  always_ff @(posedge CLK) begin
    if (RST || sel_start) begin
      line0_hi_q <= 1'b1;
    end else if (rise) begin
      line0_hi_q <= line0_hi_q & link_s.dq[0];
    end
  end
  assign forced_exit = sel_end && xip_q && line0_hi_q && state_q == xip_pkg::ST_ADDR; // [R13] [R14] [R15] [R16]

  // ****************************************************************
  // xip flag and volatile enable bit
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (RST || pin_pulse_end) begin
      xip_q <= nv_boot; // [R6] [R11] [R19]
    end else if (sample) begin
      if (!confirm && (xip_q || BASIC_XIP || !vcr_q)) begin
        xip_q <= 1'b1; // [R1] [R2] [R5] [R9]
      end else if (confirm) begin
        xip_q <= 1'b0; // [R9]
      end
    end else if (forced_exit) begin
      xip_q <= 1'b0; // [R16]
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || pin_pulse_end || SOFT_RESET) begin
      vcr_q <= xip_pkg::VCR_XIP_RESET;
    end else if ((sample && confirm && xip_q) || forced_exit) begin
      vcr_q <= 1'b1; // [R4]
    end else if (VCR_WRITE) begin
      vcr_q <= VCR_XIP_WDATA; // [R1]
    end
  end

  // ****************************************************************
  // software reset pair
  // ****************************************************************
  logic cmd_done;
  assign cmd_done = sel_end && state_q == xip_pkg::ST_IGNORE;
  always_ff @(posedge CLK) begin
    if (RST) begin
      rst_en_q <= 1'b0;
      SOFT_RESET <= 1'b0;
    end else begin
      SOFT_RESET <= cmd_done && rst_en_q && cmd_q == xip_pkg::CMD_RESET_MEMORY; // [R18] [R17]
      if (cmd_done) begin
        rst_en_q <= cmd_q == xip_pkg::CMD_RESET_ENABLE; // [R18]
      end else if (sel_end) begin
        rst_en_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ADDR_VALID <= 1'b0;
      ADDR <= 24'h000000;
    end else begin
      ADDR_VALID <= sample;
      if (sample) begin
        ADDR <= addr_q;
      end
    end
  end

  assign XIP_ACTIVE = xip_q;
  assign VCR_XIP_N = vcr_q;
  assign RESET_ENABLED = rst_en_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_confirm_one_exits;
    @(posedge CLK) disable iff (RST) (sample && confirm && !pin_pulse_end) |=> !XIP_ACTIVE;
  endproperty
  a_confirm_one_exits: assert property (p_confirm_one_exits) else $error("xip not left on confirm 1"); // [R9]
  property p_exit_sets_vcr;
    @(posedge CLK) disable iff (RST) (sample && confirm && XIP_ACTIVE) |=> VCR_XIP_N;
  endproperty
  a_exit_sets_vcr: assert property (p_exit_sets_vcr) else $error("enable bit not restored"); // [R4]
  property p_blocked_entry;
    @(posedge CLK) disable iff (RST)
      (sample && !XIP_ACTIVE && VCR_XIP_N && !BASIC_XIP && !pin_pulse_end) |=> !XIP_ACTIVE;
  endproperty
  a_blocked_entry: assert property (p_blocked_entry) else $error("xip entered while disarmed"); // [R1]
  property p_armed_entry;
    @(posedge CLK) disable iff (RST) (sample && !confirm && !VCR_XIP_N && !pin_pulse_end) |=> XIP_ACTIVE;
  endproperty
  a_armed_entry: assert property (p_armed_entry) else $error("armed entry missed"); // [R2]
  property p_basic_entry;
    @(posedge CLK) disable iff (RST) (sample && !confirm && BASIC_XIP && !pin_pulse_end) |=> XIP_ACTIVE;
  endproperty
  a_basic_entry: assert property (p_basic_entry) else $error("basic entry missed"); // [R5]
  property p_xip_frame_addr;
    @(posedge CLK) disable iff (RST) (sel_start && XIP_ACTIVE) |=> state_q == xip_pkg::ST_ADDR;
  endproperty
  a_xip_frame_addr: assert property (p_xip_frame_addr) else $error("xip frame not address first"); // [R3]
  property p_pin_reset;
    @(posedge CLK) disable iff (RST) pin_pulse_end |=> (XIP_ACTIVE == $past(nv_boot) && VCR_XIP_N);
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset state wrong"); // [R11]
  property p_forced_exit;
    @(posedge CLK) disable iff (RST) (forced_exit && !pin_pulse_end) |=> (!XIP_ACTIVE && !SOFT_RESET);
  endproperty
  a_forced_exit: assert property (p_forced_exit) else $error("forced exit wrong"); // [R16]
  property p_flag_stable;
    @(posedge CLK) disable iff (RST) (!sample && !forced_exit && !pin_pulse_end) |=> $stable(XIP_ACTIVE);
  endproperty
  a_flag_stable: assert property (p_flag_stable) else $error("xip flag moved off sample"); // [R19]
endmodule
`default_nettype wire

// file: spi_host_model.sv
// host serial controller model driving the link pins of the block
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  output logic SELECT_N,
  output logic SCLK,
  output logic [3:0] DQ
);
  // ************************
  // link timing, 48 ns clock
  // ************************
  initial begin
    SELECT_N = 1'b1;
    SCLK = 1'b0;
    DQ = 4'h5;
  end
  // sclk idles low outside frames
  task automatic tick(input logic [3:0] v);
    DQ = v;
    #24 SCLK = 1'b1;
    #24 SCLK = 1'b0;
  endtask
  // msb first, line w-1 most significant; unused lines carry their bits of the fixed pattern 4'hA
  task automatic bits(input logic [1:0] p, input logic [23:0] d, input int nb);
    int w;
    logic [3:0] v;
    w = (p == 2'h2) ? 4 : (p == 2'h1) ? 2 : 1;
    for (int i = nb - w; i >= 0; i -= w) begin
      v = 4'hA;
      for (int j = 0; j < w; j++) begin
        v[j] = d[i + j];
      end
      tick(v);
    end
  endtask
  task automatic sel();
    SELECT_N = 1'b0;
    #24;
  endtask
  // released lines flip so a stale level never looks like data
  task automatic desel();
    #12 SELECT_N = 1'b1;
    DQ = ~DQ;
    #120;
  endtask
  task automatic rd_frame(input logic [1:0] p, input logic ce, input logic [7:0] cmd,
      input logic [23:0] a, input logic cb);
    sel();
    if (ce) begin
      bits(p, {16'h0000, cmd}, 8);
    end
    bits(p, a, 24);
    tick({3'h7, cb});
    tick(4'h0);
    desel();
  endtask
  task automatic cmd_frame(input logic [7:0] cmd);
    sel();
    bits(2'h0, {16'h0000, cmd}, 8);
    desel();
  endtask
  task automatic force_exit(input int n);
    sel();
    repeat (n) tick(4'hF);
    desel();
  endtask
endmodule
`default_nettype wire

// file: xip_mode_control_tb_top.sv
// self-checking bench for the xip mode control block
`timescale 1ns/100ps
`default_nettype none
module xip_mode_control_tb_top;
  // *******************
  // signals and helpers
  // *******************
  logic clk, rst, sel_n, sclk, rpin_n, rpin_en, basic, vwr, vdat, xip, vcr_n, av, sr, re;
  logic [4:0] dclks;
  logic [3:0] dq;
  logic [1:0] proto;
  logic [11:0] nvcr;
  logic [23:0] addr, av_addr;
  logic [7:0] n_sr = 8'h00;
  int n_fail, cmp_count;
  typedef struct packed {
    logic [1:0] p;
    logic wr;
    logic ce;
    logic [7:0] cmd;
    logic [23:0] a;
    logic cb;
    logic x;
    logic vn;
  } row_type;
  row_type rows [8] = '{
    '{2'h0, 1'h0, 1'h1, 8'h0B, 24'h123456, 1'h0, 1'h0, 1'h1},
    '{2'h0, 1'h1, 1'h1, 8'h0B, 24'hABCDEF, 1'h0, 1'h1, 1'h0},
    '{2'h0, 1'h0, 1'h0, 8'h00, 24'h00FF01, 1'h0, 1'h1, 1'h0},
    '{2'h0, 1'h0, 1'h0, 8'h00, 24'hFFFFFE, 1'h1, 1'h0, 1'h1},
    '{2'h1, 1'h1, 1'h1, 8'hBB, 24'h5A5A5A, 1'h0, 1'h1, 1'h0},
    '{2'h1, 1'h0, 1'h0, 8'h00, 24'h000001, 1'h1, 1'h0, 1'h1},
    '{2'h2, 1'h1, 1'h1, 8'hEB, 24'hA5A5A5, 1'h0, 1'h1, 1'h0},
    '{2'h2, 1'h0, 1'h0, 8'h00, 24'h3C3C3C, 1'h1, 1'h0, 1'h1}};
  spi_host_model host (.SELECT_N(sel_n), .SCLK(sclk), .DQ(dq));
  xip_mode_control dut (.CLK(clk), .RST(rst), .SELECT_N(sel_n), .SCLK(sclk), .DQ_IN(dq),
    .RESET_PIN_N(rpin_n), .RESET_PIN_ENABLE(rpin_en), .BASIC_XIP(basic), .PROTOCOL(proto),
    .NVCR(nvcr), .VCR_WRITE(vwr), .VCR_XIP_WDATA(vdat), .DUMMY_CLKS(dclks),
    .XIP_ACTIVE(xip), .VCR_XIP_N(vcr_n), .ADDR_VALID(av), .ADDR(addr),
    .SOFT_RESET(sr), .RESET_ENABLED(re));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // pulses last one cycle, so capture them here rather than poll
  always @(posedge clk) begin
    if (av === 1'b1) av_addr <= addr;
    if (sr === 1'b1) n_sr <= n_sr + 8'h01;
  end
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (20) @(negedge clk);
  endtask
  task automatic do_reset();
    @(negedge clk) rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    settle();
  endtask
  task automatic vcr_write(input logic d);
    @(negedge clk) vwr = 1'b1;
    vdat = d;
    @(negedge clk) vwr = 1'b0;
  endtask
  task automatic pin_pulse();
    @(negedge clk) rpin_n = 1'b0;
    repeat (20) @(negedge clk);
    rpin_n = 1'b1;
    settle();
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    $display("ERROR t=%0t run limit reached", $time);
    results();
  end
  // ***************
  // test sequence
  // ***************
  initial begin
    {rst, basic, vwr, vdat, rpin_n, rpin_en, proto, nvcr, dclks} = {6'h27, 2'h0, 12'hE00, 5'h08};
    do_reset();
    chk(xip, 1'b0);
    chk(vcr_n, 1'b1);
    $display("reset test done");
    foreach (rows[k]) begin
      proto = rows[k].p;
      if (rows[k].wr) vcr_write(1'b0);
      host.rd_frame(rows[k].p, rows[k].ce, rows[k].cmd, rows[k].a, rows[k].cb);
      settle();
      chk(xip, rows[k].x);
      chk(vcr_n, rows[k].vn);
      chk_val(av_addr, rows[k].a);
      $display("row %0d done", k);
    end
    for (int p = 2; p >= 0; p--) begin
      proto = p[1:0];
      vcr_write(1'b0);
      host.rd_frame(p[1:0], 1'b1, (p == 2) ? 8'hEB : (p == 1) ? 8'hBB : 8'h0B, 24'h000100, 1'b0);
      settle();
      chk(xip, 1'b1);
      host.force_exit((p == 2) ? 7 : (p == 1) ? 13 : 25);
      settle();
      chk(xip, 1'b0);
      chk(vcr_n, 1'b1);
      chk_val({16'h0000, n_sr}, 24'h000000);
      $display("forced exit %0d done", p);
    end
    vcr_write(1'b0);
    host.rd_frame(2'h0, 1'b1, 8'h0B, 24'h000200, 1'b0);
    settle();
    chk(xip, 1'b1);
    host.force_exit(7);
    settle();
    chk(xip, 1'b0);
    chk(vcr_n, 1'b1);
    $display("short forced exit test done");
    proto = 2'h0;
    host.cmd_frame(8'h66);
    settle();
    chk(re, 1'b1);
    host.cmd_frame(8'h05);
    host.cmd_frame(8'h99);
    settle();
    chk_val({16'h0000, n_sr}, 24'h000000);
    vcr_write(1'b0);
    host.cmd_frame(8'h66);
    host.cmd_frame(8'h99);
    settle();
    chk_val({16'h0000, n_sr}, 24'h000001);
    chk(vcr_n, 1'b1);
    $display("soft reset test done");
    nvcr = 12'h600;
    do_reset();
    chk(xip, 1'b1);
    host.rd_frame(2'h0, 1'b0, 8'h00, 24'h000042, 1'b1);
    settle();
    chk(xip, 1'b0);
    host.sel();
    pin_pulse();
    host.desel();
    chk(xip, 1'b0);
    rpin_en = 1'b0;
    pin_pulse();
    chk(xip, 1'b0);
    rpin_en = 1'b1;
    pin_pulse();
    chk(xip, 1'b1);
    $display("boot and pin test done");
    nvcr = 12'hE00;
    basic = 1'b1;
    dclks = 5'h01;
    do_reset();
    host.rd_frame(2'h0, 1'b1, 8'h0B, 24'h000777, 1'b0);
    settle();
    chk(xip, 1'b1);
    $display("basic variant test done");
    results();
  end
endmodule
`default_nettype wire
